// [rtl/aux_out_defs.svh]
// Register indices, reset values and field positions for the aux outputs.
// Assumes the byte address of a register is four times its index.
`ifndef AUX_OUT_DEFS_SVH
`define AUX_OUT_DEFS_SVH
`define IDX_COUNTER_CTL 8'h70
`define IDX_SEQ_SELECT 8'h73
`define IDX_POLARITY 8'h75
`define IDX_SOURCE_SEL 8'h76
`define IDX_DRIVE_EN 8'h77
`define IDX_VIEW_EN 8'h78
`define IDX_TABLE_CFG 8'h79
`define IDX_POS_FIRST 8'h7A
`define IDX_POS_LAST 8'hA9
`define FIRE_LSB 6
`define TABLE_LSB 8
`define POS_W 13
`define RST_SOURCE_SEL 8'hFF
`define RST_DRIVE_EN 8'h00
`define MANUAL_FIELD 13'h0001
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [rtl/aux_out_pkg.sv]
// Types shared by the aux output block and its surroundings.
// Assumes the timing generator drives all inputs on the same clock.
package aux_out_pkg;
	typedef enum logic [2:0] {
		seq_idle,
		seq_manual,
		seq_primary,
		seq_secondary,
		seq_mode,
		seq_primary_repeat,
		seq_secondary_repeat,
		seq_keep_on
	} sequence_select_type;
	typedef struct packed {
		logic field_start;
		logic [12:0] line;
		logic [12:0] pixel;
		logic primary_run;
		logic [12:0] primary;
		logic primary_wrap;
		logic secondary_run;
		logic [12:0] secondary;
		logic secondary_wrap;
		logic [12:0] mode;
	} timing_type;
	typedef struct packed {
		logic substrate_clock;
		logic [3:0] vertical_clock;
		logic output_control;
		logic horizontal_blanking;
		logic optical_black_clamp;
		logic pixel_blanking;
	} view_type;
	typedef struct packed {
		logic awready;
		logic aw_held;
		logic [7:0] aw_idx;
		logic wready;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] fire;
		logic [7:0] window;
		logic [7:0] spent;
		logic [23:0] seq;
		logic [7:0] pol;
		logic [7:0] src_sel;
		logic [7:0] drive;
		logic view;
		logic [23:0] table_cfg;
		logic [47:0][25:0] pos;
		logic [7:0] level;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
	} aux_state_type;
endpackage

// [rtl/field_scheduled_aux_outputs.sv]
// Eight field scheduled auxiliary outputs with an AXI4-Lite register port.
// Assumes field, line and pixel counts come from the timing generator on
// aclk, with field_start a one-cycle pulse at each field boundary.
//
// Local design decision: register access over AXI4-Lite.
`include "aux_out_defs.svh"

// Notes on behaviour
// [RQ1] Code 0 idles, 1 manual, 7 on
// [RQ2] Code 2 follows primary field counter
// [RQ3] Code 3 follows secondary field counter
// [RQ4] Code 4 follows mode field counter
// [RQ5] Code 5 repeats with primary wraps
// [RQ6] Code 6 repeats with secondary wraps
// [RQ7] Fire bit per signal starts manual toggles
// [RQ8] Start polarity loads only while idle
// [RQ9] Cleared source bit shows substrate clock on pin 4, vertical clocks on pins 5-8
// [RQ10] Drive enable bit drives pin, else float
// [RQ11] Route bit picks table or own level
// [RQ12] Four-bit truth table per signal pair
// [RQ13] Field position relative to linked counter
// [RQ14] Line and pixel position within field
// [RQ15] View enable shows internal timing pins 5-8
// [RQ16] Manual toggles only in following field
// [RQ17] Host writes fire bits after code 1
// [RQ18] Host sets manual field positions to 1
// [RQ19] Host refires each field for repeats
// [RQ20] Host returns code to idle after use
// [RQ21] Codes 2/3 toggle over counted fields once
// [RQ22] Repeat codes toggle while counter repeats
// [RQ23] Pair pin gives table or own level
// [RQ24] Sequence selects sit at index 73h
// [RQ25] Host spaces control writes one field
// [RQ26] Matching positions invert level in order
module field_scheduled_aux_outputs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire aux_out_pkg::timing_type timing,
	input wire aux_out_pkg::view_type view_in,
	output logic [7:0] aux_pin_out,
	output logic [7:0] aux_pin_oe
);

	aux_out_pkg::aux_state_type s;
	aux_out_pkg::aux_state_type next_s;
	logic ctl_write;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] code_of(
		input logic [23:0] seq,
		input int i
	);
		return seq[3*i +: 3];
	endfunction

	// Returns {enable, active field count} for one signal
	function automatic logic [13:0] field_of(
		input logic [2:0] code,
		input aux_out_pkg::timing_type t,
		input logic win,
		input logic spent
	);
		logic [13:0] r;
		r = 14'h0000;
		case (aux_out_pkg::sequence_select_type'(code))
			aux_out_pkg::seq_manual: begin
				r = {win, `MANUAL_FIELD}; // RQ16
			end
			aux_out_pkg::seq_primary: begin
				r = {t.primary_run & ~spent, t.primary}; // RQ2
			end
			aux_out_pkg::seq_secondary: begin
				r = {t.secondary_run & ~spent, t.secondary}; // RQ3
			end
			aux_out_pkg::seq_mode: begin
				r = {1'b1, t.mode}; // RQ4
			end
			aux_out_pkg::seq_primary_repeat: begin
				// Wraps reset the count, so matches recur
				r = {t.primary_run, t.primary}; // RQ5
			end
			aux_out_pkg::seq_secondary_repeat: begin
				r = {t.secondary_run, t.secondary}; // RQ6
			end
			default: begin
				r = 14'h0000;
			end
		endcase
		return r;
	endfunction

	// Returns {error, data} for a register read
	function automatic logic [32:0] read_reg(
		input aux_out_pkg::aux_state_type st,
		input logic [7:0] idx
	);
		logic [32:0] r;
		r = 33'h000000000;
		case (idx)
			`IDX_COUNTER_CTL: r[`FIRE_LSB +: 8] = st.fire;
			`IDX_SEQ_SELECT: r[23:0] = st.seq;
			`IDX_POLARITY: r[7:0] = st.pol;
			`IDX_SOURCE_SEL: r[7:0] = st.src_sel;
			`IDX_DRIVE_EN: r[7:0] = st.drive;
			`IDX_VIEW_EN: r[0] = st.view;
			`IDX_TABLE_CFG: r[23:0] = st.table_cfg;
			default: begin
				if (idx >= `IDX_POS_FIRST && idx <= `IDX_POS_LAST) begin
					r[25:0] = st.pos[idx - `IDX_POS_FIRST];
				end else begin
					r[32] = 1'b1;
				end
			end
		endcase
		return r;
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [32:0] rd;
		logic [31:0] w;
		logic [13:0] fc;
		logic [12:0] fpos;
		logic [12:0] lpos;
		logic [12:0] ppos;
		logic [2:0] code;
		logic [3:0] tbl;
		logic lv;
		logic base;
		logic [5:0] ti;
		rd = 33'h000000000;
		w = 32'h00000000;
		fc = 14'h0000;
		fpos = 13'h0000;
		lpos = 13'h0000;
		ppos = 13'h0000;
		code = 3'h0;
		tbl = 4'h0;
		lv = 1'b0;
		base = 1'b0;
		ti = 6'h00;
		next_s = s;
		ctl_write = 1'b0;

		// Bus handshakes
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_idx = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			rd = read_reg(s, s_axi_araddr[9:2]);
			next_s.rvalid = 1'b1;
			next_s.rdata = rd[31:0];
			next_s.rresp = rd[32] ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// Fire bits clear at each field start; a write in the same
		// cycle lands afterwards, so it is not lost
		if (timing.field_start) begin
			for (int i = 0; i < 8; i++) begin
				code = code_of(s.seq, i);
				next_s.window[i] = s.fire[i] &&
					code == 3'(aux_out_pkg::seq_manual); // RQ7 RQ16
			end
			next_s.fire = 8'h00;
		end

		// Register write once address and data are both held
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `RESP_OKAY;
			rd = read_reg(s, s.aw_idx);
			w = merge(rd[31:0], s.wdata, s.wstrb);
			case (s.aw_idx)
				`IDX_COUNTER_CTL: begin
					ctl_write = 1'b1;
					next_s.fire = next_s.fire |
						w[`FIRE_LSB +: 8]; // RQ7
				end
				`IDX_SEQ_SELECT: next_s.seq = w[23:0]; // RQ24
				`IDX_POLARITY: next_s.pol = w[7:0];
				`IDX_SOURCE_SEL: next_s.src_sel = w[7:0];
				`IDX_DRIVE_EN: next_s.drive = w[7:0];
				`IDX_VIEW_EN: next_s.view = w[0];
				`IDX_TABLE_CFG: next_s.table_cfg = w[23:0];
				default: begin
					if (rd[32]) begin
						next_s.bresp = `RESP_SLVERR;
					end else begin
						next_s.pos[s.aw_idx - `IDX_POS_FIRST] =
							w[25:0]; // RQ13 RQ14
					end
				end
			endcase
		end
		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready = !next_s.w_held && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;

		// Per signal level
		for (int i = 0; i < 8; i++) begin
			code = code_of(s.seq, i);
			lv = s.level[i];
			fc = field_of(code, timing, s.window[i], s.spent[i]);
			case (aux_out_pkg::sequence_select_type'(code))
				aux_out_pkg::seq_idle: begin
					lv = s.pol[i]; // RQ8 RQ1
					next_s.spent[i] = 1'b0;
					next_s.window[i] = 1'b0;
				end
				aux_out_pkg::seq_keep_on: begin
					lv = 1'b1; // RQ1
				end
				default: begin
					// Toggles applied in number order
					for (int t = 0; t < 4; t++) begin
						ti = 6'(6 * i + 3 * (t / 2));
						fpos = s.pos[ti][13 * (t % 2) +: 13];
						lpos = s.pos[ti + 6'h01][13 * (t % 2) +: 13];
						ppos = s.pos[ti + 6'h02][13 * (t % 2) +: 13];
						if (fc[13] && fc[12:0] == fpos &&
							timing.line == lpos &&
							timing.pixel == ppos) begin
							lv = ~lv; // RQ26 RQ13 RQ14
						end
					end
				end
			endcase
			next_s.level[i] = lv;
			// One pass only for the primary and secondary links, codes 2 and 3
			if ((code == 3'(aux_out_pkg::seq_primary) &&
				timing.primary_wrap) ||
				(code == 3'(aux_out_pkg::seq_secondary) &&
				timing.secondary_wrap)) begin
				next_s.spent[i] = 1'b1; // RQ21 RQ22
			end
		end

		// Pin selection
		for (int i = 0; i < 8; i++) begin
			tbl = s.table_cfg[`TABLE_LSB + 4 * (i / 2) +: 4];
			base = s.level[i];
			if (s.table_cfg[i]) begin
				base = tbl[{s.level[i | 1], s.level[i & 6]}]; // RQ11 RQ12
			end
			if (!s.src_sel[i] && i >= 3) begin
				base = (i == 3) ? view_in.substrate_clock :
					view_in.vertical_clock[2'(i)]; // RQ9
			end
			if (s.view && i >= 4) begin
				case (i)
					4: base = view_in.output_control; // RQ15
					5: base = view_in.horizontal_blanking;
					6: base = view_in.optical_black_clamp;
					default: base = view_in.pixel_blanking;
				endcase
			end
			next_s.pin_out[i] = base; // RQ23
		end
		next_s.pin_oe = s.drive; // RQ10
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.src_sel <= `RST_SOURCE_SEL;
			s.drive <= `RST_DRIVE_EN;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign aux_pin_out = s.pin_out;
	assign aux_pin_oe = s.pin_oe;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_idle_polarity: // RQ8
	assert property (s.seq[2:0] == 3'h0 |=> s.level[0] == $past(s.pol[0]))
		else $error("idle level not start polarity");
	a_keep_on_high: // RQ1
	assert property (s.seq[2:0] == 3'h7 |=> s.level[0])
		else $error("keep on level not high");
	a_manual_arm: // RQ7
	assert property (timing.field_start && s.fire[0] &&
		s.seq[2:0] == 3'h1 |=> s.window[0])
		else $error("fired signal not armed");
	a_window_cause: // RQ16
	assert property ($rose(s.window[0]) |-> $past(timing.field_start))
		else $error("window opened outside field start");
	a_fire_clear: // RQ7
	assert property (timing.field_start && !ctl_write |=> s.fire == 8'h00)
		else $error("fire bits not cleared");
	a_spent_hold: // RQ21
	assert property (s.spent[1] && s.seq[5:3] == 3'h2 &&
		$stable(s.seq) |=> $stable(s.level[1]))
		else $error("spent signal toggled");
	a_pin_float: // RQ10
	assert property (!s.drive[0] ##1 !s.drive[0] |-> !aux_pin_oe[0])
		else $error("undriven pin enabled");
	a_view_pin5: // RQ15
	assert property (s.view |=> aux_pin_out[4] ==
		$past(view_in.output_control))
		else $error("internal view missing on pin 5");
	a_table_xor: // RQ12
	assert property (s.table_cfg[0] && s.table_cfg[11:8] == 4'h6 |=>
		aux_pin_out[0] == ($past(s.level[0]) ^ $past(s.level[1])))
		else $error("xor table wrong");
	a_write_answer: // RQ24
	assert property (s.aw_held && s.w_held && !s.bvalid |=> s.bvalid)
		else $error("write not answered");

	c_manual: cover property (s.window[0] && s.level[0] != $past(s.level[0]));
	c_spent: cover property ($rose(s.spent[1]));
	c_table: cover property (s.table_cfg[1] && aux_pin_out[1]);
	c_error: cover property (s.bvalid && s.bresp == `RESP_SLVERR);

endmodule

// [tb/test_field_scheduled_aux_outputs.sv]
// Testbench: register accesses over AXI4-Lite, pin levels compared.
// Assumes the timing_source partner and a 250 MHz aclk.
module test_field_scheduled_aux_outputs;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, run;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] aux_pin_out, aux_pin_oe, base;
	aux_out_pkg::timing_type tim;
	aux_out_pkg::view_type view_value, view_in;
	int errors, n_compared;
	logic [3:0] tabs [4] = '{4'h6, 4'h7, 4'h8, 4'hE};
	logic [3:0] e01 = 4'b1011;
	logic [3:0] e11 = 4'b1100;
	field_scheduled_aux_outputs dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .timing(tim),
		.view_in(view_in), .aux_pin_out(aux_pin_out),
		.aux_pin_oe(aux_pin_oe));
	timing_source src (.aclk(aclk), .aresetn(aresetn), .run(run),
		.view_value(view_value), .timing(tim), .view_in(view_in));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] v);
		logic a, w;
		@(posedge aclk);
		awaddr <= {22'h000000, i, 2'h0};
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		a = 1'b0;
		w = 1'b0;
		while (!(a && w)) begin
			@(posedge aclk);
			if (!a && awready) begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, output logic [31:0] v);
		@(posedge aclk);
		araddr <= {22'h000000, i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic pins(input string nm, input logic [7:0] e);
		repeat (4) @(posedge aclk);
		chk(nm, {24'h000000, e}, {24'h000000, aux_pin_out});
	endtask
	// Bounded wait, the count keeps a stuck pin from hanging the run
	task automatic wait_pin(input int n, input logic v, input string nm);
		int k;
		k = 0;
		while (aux_pin_out[n] !== v && k < 300) begin
			@(posedge aclk);
			k++;
		end
		chk(nm, {31'h0, v}, {31'h0, aux_pin_out[n]});
	endtask
	task automatic summarize;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ****************
	// Sequence
	// ****************
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		summarize;
	end
	initial begin
		{aresetn, run, awaddr, wdata, araddr, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		view_value = '0;
		errors = 0;
		n_compared = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h76, d);
		chk("source reset", 32'h000000FF, d);
		rd(8'h77, d);
		chk("drive reset", 32'h00000000, d);
		chk("oe reset", 32'h00000000, {24'h000000, aux_pin_oe});
		rd(8'h10, d);
		chk("unmapped rresp", 32'h00000002, {30'h0, resp});
		wr(8'h10, 32'hFFFFFFFF);
		chk("unmapped bresp", 32'h00000002, {30'h0, resp});
		wr(8'h77, 32'h000000FF);
		repeat (4) @(posedge aclk);
		chk("oe on", 32'h000000FF, {24'h000000, aux_pin_oe});
		wr(8'h75, 32'h0000005A);
		pins("polarity", 8'h5A);
		wr(8'h73, 32'h00FFFFFF);
		pins("keep on", 8'hFF);
		rd(8'h73, d);
		chk("sequence readback", 32'h00FFFFFF, d);
		wr(8'h73, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			wr(8'h75, 32'h00000001);
			wr(8'h79, {20'h00000, tabs[i], 8'h03});
			pins("table 01", {6'h00, {2{e01[i]}}});
			wr(8'h75, 32'h00000003);
			pins("table 11", {6'h00, {2{e11[i]}}});
		end
		wr(8'h79, 32'h00000000);
		wr(8'h75, 32'h000000FF);
		view_value <= 9'h056;
		wr(8'h76, 32'h00000000);
		pins("vertical view", 8'h57);
		wr(8'h78, 32'h00000001);
		pins("internal view", 8'h67);
		wr(8'h78, 32'h00000000);
		wr(8'h76, 32'h000000FF);
		wr(8'h75, 32'h00000000);
		// Manual: two toggles in the field after the fire write
		wr(8'h7A, 32'h00002001);
		wr(8'h7B, 32'h00004001);
		wr(8'h7C, 32'h00000003);
		wr(8'h73, 32'h00000001);
		wr(8'h70, 32'h00000040);
		wait_pin(0, 1'b1, "manual first");
		wait_pin(0, 1'b0, "manual second");
		repeat (64) @(posedge aclk);
		chk("manual quiet", 32'h0, {31'h0, aux_pin_out[0]});
		// Well over a field since the last trigger write
		wr(8'h70, 32'h00000040);
		wait_pin(0, 1'b1, "manual refire");
		wait_pin(0, 1'b0, "manual refire end");
		wr(8'h73, 32'h00000000);
		for (int c = 2; c < 7; c++) begin
			run <= 1'b0;
			repeat (40) @(posedge aclk);
			base = 8'h7A + 8'(6 * (c - 1));
			wr(base, 32'h03FFE002);
			wr(base + 8'h01, 32'h00000001);
			wr(base + 8'h02, 32'h00000002);
			wr(8'h73, 32'(c) << (3 * (c - 1)));
			run <= 1'b1;
			wait_pin(c - 1, 1'b1, "scheduled");
			if (c == 2) begin
				repeat (128) @(posedge aclk);
				chk("single pass", 32'h1, {31'h0, aux_pin_out[1]});
			end
			if (c == 5) begin
				wait_pin(4, 1'b0, "repeat");
			end
		end
		summarize;
	end
endmodule

// [tb/timing_source.sv]
// Partner model: timing generator feeding field, line, pixel and counters.
// Assumes one aclk domain shared with the aux output block.
module timing_source #(
	parameter int PIX = 8,
	parameter int LIN = 4,
	parameter int MAXC = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire aux_out_pkg::view_type view_value,
	output aux_out_pkg::timing_type timing,
	output aux_out_pkg::view_type view_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Counters
	// ****************
	// Stopped counters read 0, so no toggle position of 0 can match late
	function automatic logic [12:0] step(input logic [12:0] c, input logic on);
		return !on ? 13'h0000 : (c == 13'(MAXC)) ? 13'h0001 : c + 13'h0001;
	endfunction
	assign view_in = view_value;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timing <= '0;
		end else begin
			timing.field_start <= 1'b0;
			timing.primary_wrap <= 1'b0;
			timing.secondary_wrap <= 1'b0;
			if (timing.pixel != 13'(PIX - 1)) begin
				timing.pixel <= timing.pixel + 13'h0001;
			end else if (timing.line != 13'(LIN - 1)) begin
				timing.pixel <= '0;
				timing.line <= timing.line + 13'h0001;
			end else begin
				timing.pixel <= '0;
				timing.line <= '0;
				timing.field_start <= 1'b1;
				timing.primary_run <= run;
				timing.secondary_run <= run;
				timing.primary <= step(timing.primary, run);
				timing.secondary <= step(timing.secondary, run);
				timing.mode <= step(timing.mode, 1'b1);
				timing.primary_wrap <= run && timing.primary == 13'(MAXC);
				timing.secondary_wrap <= run && timing.secondary == 13'(MAXC);
			end
		end
	end
endmodule
